//--- rtl/fiw_flash_iap.sv
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module fiw_flash_iap #(
    parameter int ADDR_W = fiw_pkg::ADDR_W,
    parameter int ERASE_CYCLES = fiw_pkg::ERASE_CYCLES,
    parameter int WRITE_CYCLES = fiw_pkg::WRITE_CYCLES,
    parameter int UNLOCK_CYCLES = fiw_pkg::UNLOCK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [fiw_pkg::REG_AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic flash_wr_out,
    output logic [ADDR_W-1:0] flash_addr_out,
    output logic [fiw_pkg::WORD_W-1:0] flash_wdata_out,
    output logic flash_busy_out
);
    localparam int PW = fiw_pkg::PAGE_W;

    fiw_wbuf_if wbuf ();

    logic [7:0] data_lo_reg [4];
    logic [7:0] data_hi_reg [4];
    logic [ADDR_W-1:0] addr_reg;
    logic [2:0] mode_reg;
    logic perm_reg;
    logic trig_reg;
    logic clr_reg;
    logic [7:0] rdata_reg;
    fiw_pkg::fiw_state_t state_reg;
    logic [PW-1:0] idx_reg;
    logic op_erase_reg;
    logic [fiw_pkg::CNT_W-1:0] cnt_reg;
    logic pend_reg;
    logic [PW-1:0] pend_idx_reg;
    logic flash_wr_reg;
    logic [ADDR_W-1:0] flash_addr_reg;
    logic [fiw_pkg::WORD_W-1:0] flash_wdata_reg;

    logic wr_ctrl0;
    logic wr_ctrl2;
    logic load;
    logic unlock_start;
    logic unlock_busy;
    logic unlock_grant;
    logic op_ok;
    logic done;
    logic [5:0] key_wr;

    function automatic logic dw_hit(input logic [3:0] a);
        return a >= fiw_pkg::REG_DW_FIRST && a <= fiw_pkg::REG_DW_LAST;
    endfunction

    function automatic logic [1:0] dw_word(input logic [3:0] a);
        logic [3:0] off;
        off = a - fiw_pkg::REG_DW_FIRST;
        return off[2:1];
    endfunction

    // next address, held at the last word of the page
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a);
        if (&a[PW-1:0]) begin
            return a;
        end
        return ADDR_W'(a + 1'b1);
    endfunction

    assign wr_ctrl0 = wr_in && addr_in == fiw_pkg::REG_CTRL0;
    assign wr_ctrl2 = wr_in && addr_in == fiw_pkg::REG_CTRL2;
    assign load = wr_in && addr_in == fiw_pkg::REG_DW0_HI;
    assign unlock_start = wr_ctrl0 && wdata_in[fiw_pkg::CTRL0_UNLOCK_BIT]
        && wdata_in[fiw_pkg::CTRL0_MODE_LSB+:3] == fiw_pkg::FIW_MODE_UNLOCK;

    // key byte write strobes: words one to three low, then high
    always_comb begin
        key_wr = 6'h00;
        if (wr_in && dw_hit(addr_in) && dw_word(addr_in) != 2'd0) begin
            if (addr_in[0]) begin
                key_wr[3'd3 - 3'(dw_word(addr_in))] = 1'b1;
            end else begin
                key_wr[3'd6 - 3'(dw_word(addr_in))] = 1'b1;
            end
        end
    end

    fiw_unlock #(
        .TIME_CYCLES(UNLOCK_CYCLES)
    ) u_unlock (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(unlock_start),
        .key_wr_in(key_wr),
        .key_in({data_lo_reg[1], data_lo_reg[2], data_lo_reg[3],
                 data_hi_reg[1], data_hi_reg[2], data_hi_reg[3]}),
        .busy_out(unlock_busy),
        .grant_out(unlock_grant)
    );

    fiw_wbuf_mem #(
        .DEPTH(fiw_pkg::BUF_DEPTH),
        .W(fiw_pkg::WORD_W)
    ) u_wbuf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .bus(wbuf.mem)
    );

    // buffer slot follows the in-page address bits
    assign wbuf.wr_en = load;
    assign wbuf.wr_idx = addr_reg[PW-1:0];
    assign wbuf.wr_data = {wdata_in, data_lo_reg[0]};
    assign wbuf.clr = clr_reg;
    assign wbuf.rd_idx = idx_reg;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                data_lo_reg[i] <= fiw_pkg::BYTE_RST;
                data_hi_reg[i] <= fiw_pkg::BYTE_RST;
            end
        end else if (wr_in && dw_hit(addr_in)) begin
            if (addr_in[0]) begin
                data_hi_reg[dw_word(addr_in)] <= wdata_in;
            end else begin
                data_lo_reg[dw_word(addr_in)] <= wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_reg <= '0;
        end else if (wr_in && addr_in == fiw_pkg::REG_ADDR_LO) begin
            addr_reg[7:0] <= wdata_in;
        end else if (wr_in && addr_in == fiw_pkg::REG_ADDR_HI) begin
            addr_reg[ADDR_W-1:8] <= wdata_in[ADDR_W-9:0];
        end else if (load) begin
            addr_reg <= next_addr(addr_reg);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_reg <= fiw_pkg::MODE_RST;
        end else if (wr_ctrl0) begin
            mode_reg <= wdata_in[fiw_pkg::CTRL0_MODE_LSB+:3];
        end
    end

    // a grant in the same cycle as a software clear wins
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            perm_reg <= 1'b0;
        end else if (unlock_grant) begin
            perm_reg <= 1'b1;
        end else if (wr_ctrl0 && !wdata_in[fiw_pkg::CTRL0_PERM_BIT]) begin
            perm_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            clr_reg <= 1'b0;
        end else if (wr_ctrl2 && wdata_in[fiw_pkg::CTRL2_CLR_BIT]) begin
            clr_reg <= 1'b1;
        end else begin
            clr_reg <= 1'b0;
        end
    end

    // a new trigger is taken only when idle, so set and done never meet
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            trig_reg <= 1'b0;
        end else if (wr_ctrl0 && wdata_in[fiw_pkg::CTRL0_TRIG_BIT] && !trig_reg) begin
            trig_reg <= 1'b1;
        end else if (done) begin
            trig_reg <= 1'b0;
        end
    end

    assign op_ok = perm_reg && (mode_reg == fiw_pkg::FIW_MODE_WRITE || mode_reg == fiw_pkg::FIW_MODE_ERASE);
    assign done = (state_reg == fiw_pkg::FIW_IDLE && trig_reg && !op_ok)
        || (state_reg == fiw_pkg::FIW_WAIT && cnt_reg == '0);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= fiw_pkg::FIW_IDLE;
            idx_reg <= '0;
            op_erase_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                fiw_pkg::FIW_IDLE: begin
                    idx_reg <= '0;
                    if (trig_reg && op_ok) begin
                        state_reg <= fiw_pkg::FIW_SCAN;
                        op_erase_reg <= mode_reg == fiw_pkg::FIW_MODE_ERASE;
                    end
                end
                fiw_pkg::FIW_SCAN: begin
                    idx_reg <= PW'(idx_reg + 1'b1);
                    if (&idx_reg) begin
                        state_reg <= fiw_pkg::FIW_WAIT;
                        cnt_reg <= op_erase_reg ? fiw_pkg::CNT_W'(ERASE_CYCLES - 1)
                                                : fiw_pkg::CNT_W'(WRITE_CYCLES - 1);
                    end
                end
                fiw_pkg::FIW_WAIT: begin
                    cnt_reg <= cnt_reg - 1'b1;
                    if (cnt_reg == '0) begin
                        state_reg <= fiw_pkg::FIW_IDLE;
                    end
                end
                default: begin
                    state_reg <= fiw_pkg::FIW_IDLE;
                end
            endcase
        end
    end

    // buffer read data arrive one cycle after the slot index
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend_reg <= 1'b0;
            pend_idx_reg <= '0;
        end else begin
            pend_reg <= state_reg == fiw_pkg::FIW_SCAN;
            pend_idx_reg <= idx_reg;
        end
    end

    // untagged slots never reach the array
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            flash_wr_reg <= 1'b0;
            flash_addr_reg <= '0;
            flash_wdata_reg <= '0;
        end else begin
            flash_wr_reg <= pend_reg && wbuf.rd_tag && perm_reg;
            flash_addr_reg <= {addr_reg[ADDR_W-1:PW], pend_idx_reg};
            flash_wdata_reg <= op_erase_reg ? '0 : wbuf.rd_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_reg <= 8'h00;
        end else if (!rd_in) begin
            rdata_reg <= 8'h00;
        end else if (dw_hit(addr_in)) begin
            rdata_reg <= addr_in[0] ? data_hi_reg[dw_word(addr_in)] : data_lo_reg[dw_word(addr_in)];
        end else begin
            unique case (addr_in)
                fiw_pkg::REG_CTRL0: rdata_reg <= {perm_reg, mode_reg, unlock_busy, trig_reg, 2'b00};
                fiw_pkg::REG_CTRL2: rdata_reg <= {7'h00, clr_reg};
                fiw_pkg::REG_ADDR_LO: rdata_reg <= addr_reg[7:0];
                fiw_pkg::REG_ADDR_HI: rdata_reg <= 8'(addr_reg >> 8);
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign rdata_out = rdata_reg;
    assign flash_wr_out = flash_wr_reg;
    assign flash_addr_out = flash_addr_reg;
    assign flash_wdata_out = flash_wdata_reg;
    assign flash_busy_out = trig_reg;
endmodule

//--- shared/fiw_pkg.sv
package fiw_pkg;

    // array geometry
    localparam int ADDR_W = 13;
    localparam int PAGE_W = 5;
    localparam int BUF_DEPTH = 32;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int REG_AW = 4;

    // register offsets on the byte-wide register port
    localparam logic [3:0] REG_CTRL0 = 4'h0;
    localparam logic [3:0] REG_CTRL2 = 4'h1;
    localparam logic [3:0] REG_ADDR_LO = 4'h2;
    localparam logic [3:0] REG_ADDR_HI = 4'h3;
    localparam logic [3:0] REG_DW_FIRST = 4'h4;
    localparam logic [3:0] REG_DW0_HI = 4'h5;
    localparam logic [3:0] REG_DW_LAST = 4'hb;

    // field positions
    localparam int CTRL0_PERM_BIT = 7;
    localparam int CTRL0_MODE_LSB = 4;
    localparam int CTRL0_UNLOCK_BIT = 3;
    localparam int CTRL0_TRIG_BIT = 2;
    localparam int CTRL2_CLR_BIT = 0;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;

    typedef enum logic [2:0] {
        FIW_MODE_WRITE = 3'b000,
        FIW_MODE_ERASE = 3'b001,
        FIW_MODE_READ = 3'b011,
        FIW_MODE_UNLOCK = 3'b110
    } fiw_mode_t;

    typedef enum logic [1:0] {
        FIW_IDLE = 2'b00,
        FIW_SCAN = 2'b01,
        FIW_WAIT = 2'b10
    } fiw_state_t;

    // unlock key, words one to three, low then high bytes
    localparam logic [7:0] KEY_W1_LO = 8'h00;
    localparam logic [7:0] KEY_W2_LO = 8'h0d;
    localparam logic [7:0] KEY_W3_LO = 8'hc3;
    localparam logic [7:0] KEY_W1_HI = 8'h04;
    localparam logic [7:0] KEY_W2_HI = 8'h09;
    localparam logic [7:0] KEY_W3_HI = 8'h40;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int ERASE_TIME_US = 3200;
    localparam int WRITE_TIME_US = 2200;
    localparam int UNLOCK_TIME_US = 20;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    localparam int UNLOCK_CYCLES = UNLOCK_TIME_US * CLK_MHZ;
    localparam int CNT_W = 20;

endpackage

//--- shared/fiw_wbuf_if.sv
`timescale 1ns/1ps
interface fiw_wbuf_if;
    logic wr_en;
    logic [fiw_pkg::PAGE_W-1:0] wr_idx;
    logic [fiw_pkg::WORD_W-1:0] wr_data;
    logic clr;
    logic [fiw_pkg::PAGE_W-1:0] rd_idx;
    logic [fiw_pkg::WORD_W-1:0] rd_data;
    logic rd_tag;

    modport ctrl(output wr_en, output wr_idx, output wr_data, output clr, output rd_idx,
                 input rd_data, input rd_tag);
    modport mem(input wr_en, input wr_idx, input wr_data, input clr, input rd_idx,
                output rd_data, output rd_tag);
endinterface

//--- rtl/fiw_wbuf_mem.sv
`timescale 1ns/1ps
module fiw_wbuf_mem #(
    parameter int DEPTH = fiw_pkg::BUF_DEPTH,
    parameter int W = fiw_pkg::WORD_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    fiw_wbuf_if.mem bus
);
    logic [W-1:0] word_mem [DEPTH];
    logic [DEPTH-1:0] tag_reg;
    logic [W-1:0] rd_data_reg;
    logic rd_tag_reg;

    // clearing only the tags empties the buffer in one cycle without a wide reset
    // a load in the clear cycle still tags its slot, so back-to-back writes are not lost
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tag_reg <= '0;
        end else begin
            tag_reg <= (bus.clr ? '0 : tag_reg) | (DEPTH'(bus.wr_en) << bus.wr_idx);
        end
    end

    always_ff @(posedge clk_in) begin
        if (bus.wr_en) begin
            word_mem[bus.wr_idx] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_reg <= '0;
            rd_tag_reg <= 1'b0;
        end else begin
            rd_tag_reg <= tag_reg[bus.rd_idx] && !bus.clr;
            rd_data_reg <= tag_reg[bus.rd_idx] ? word_mem[bus.rd_idx] : '0;
        end
    end

    assign bus.rd_data = rd_data_reg;
    assign bus.rd_tag = rd_tag_reg;
endmodule

//--- rtl/fiw_unlock.sv
`timescale 1ns/1ps
module fiw_unlock #(
    parameter int TIME_CYCLES = fiw_pkg::UNLOCK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [5:0] key_wr_in,
    input wire logic [47:0] key_in,
    output logic busy_out,
    output logic grant_out
);
    logic [fiw_pkg::CNT_W-1:0] cnt_reg;
    logic [5:0] seen_reg;
    logic done_reg;
    logic key_ok;

    // key_in packs low bytes of words one to three, then their high bytes
    assign key_ok = key_in == {fiw_pkg::KEY_W1_LO, fiw_pkg::KEY_W2_LO, fiw_pkg::KEY_W3_LO,
                               fiw_pkg::KEY_W1_HI, fiw_pkg::KEY_W2_HI, fiw_pkg::KEY_W3_HI};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            cnt_reg <= '0;
        end else if (start_in) begin
            busy_out <= 1'b1;
            cnt_reg <= fiw_pkg::CNT_W'(TIME_CYCLES - 1);
        end else if (busy_out) begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == '0) begin
                busy_out <= 1'b0;
            end
        end
    end

    // stale key bytes left from an earlier try must not grant by themselves
    always_ff @(posedge clk_in) begin
        if (rst_in || start_in) begin
            seen_reg <= '0;
        end else if (busy_out) begin
            seen_reg <= seen_reg | key_wr_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || start_in) begin
            done_reg <= 1'b0;
            grant_out <= 1'b0;
        end else begin
            grant_out <= busy_out && !done_reg && (&seen_reg) && key_ok;
            if (busy_out && (&seen_reg) && key_ok) begin
                done_reg <= 1'b1;
            end
        end
    end
endmodule

//--- dv/fiw_flash_iap_assertions.sv
`timescale 1ns/1ps
module fiw_flash_iap_assertions #(
    parameter int ADDR_W = 13,
    parameter int ERASE_CYCLES = 40,
    parameter int WRITE_CYCLES = 30
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic flash_wr_out,
    input wire logic [ADDR_W-1:0] flash_addr_out,
    input wire logic [15:0] flash_wdata_out,
    input wire logic flash_busy_out
);
    localparam int BUSY_MAX = (ERASE_CYCLES > WRITE_CYCLES ? ERASE_CYCLES : WRITE_CYCLES) + 40;
    logic [12:0] addr_reg;
    logic [12:0] seen_reg;
    logic [2:0] mode_reg;
    logic [31:0] busy_cnt_reg;
    logic rd_lo_reg;
    logic rd_hi_reg;
    logic rd_unm_reg;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // shadow of the address pair, saturating at the last word of the page
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            addr_reg <= 13'h0000;
        end else if (wr_in && addr_in == fiw_pkg::REG_ADDR_LO) begin
            addr_reg[7:0] <= wdata_in;
        end else if (wr_in && addr_in == fiw_pkg::REG_ADDR_HI) begin
            addr_reg[12:8] <= wdata_in[4:0];
        end else if (wr_in && addr_in == fiw_pkg::REG_DW0_HI && addr_reg[4:0] != 5'h1f) begin
            addr_reg <= addr_reg + 13'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mode_reg <= 3'h0;
        end else if (wr_in && addr_in == fiw_pkg::REG_CTRL0) begin
            mode_reg <= wdata_in[6:4];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !flash_busy_out) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_lo_reg <= 1'b0;
            rd_hi_reg <= 1'b0;
            rd_unm_reg <= 1'b0;
            seen_reg <= 13'h0000;
        end else begin
            rd_lo_reg <= rd_in && addr_in == fiw_pkg::REG_ADDR_LO;
            rd_hi_reg <= rd_in && addr_in == fiw_pkg::REG_ADDR_HI;
            rd_unm_reg <= rd_in && addr_in >= 4'hc;
            seen_reg <= addr_reg;
        end
    end

    property p_rd_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside its slot");

    property p_unmapped;
        rd_unm_reg |-> rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_addr_lo;
        rd_lo_reg |-> rdata_out == seen_reg[7:0];
    endproperty
    a_addr_lo: assert property (p_addr_lo)
        else $error("address low byte wrong");

    property p_addr_hi;
        rd_hi_reg |-> rdata_out == {3'h0, seen_reg[12:8]};
    endproperty
    a_addr_hi: assert property (p_addr_hi)
        else $error("address high byte wrong");

    property p_page;
        flash_wr_out |-> flash_addr_out[12:5] == addr_reg[12:5];
    endproperty
    a_page: assert property (p_page)
        else $error("array write outside selected page");

    property p_erase_zero;
        flash_wr_out && mode_reg == fiw_pkg::FIW_MODE_ERASE |-> flash_wdata_out == 16'h0000;
    endproperty
    a_erase_zero: assert property (p_erase_zero)
        else $error("erase wrote nonzero word");

    property p_busy_wr;
        flash_wr_out |-> flash_busy_out;
    endproperty
    a_busy_wr: assert property (p_busy_wr)
        else $error("array write with trigger low");

    property p_busy_bound;
        flash_busy_out |-> busy_cnt_reg < BUSY_MAX;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("trigger never cleared");

    property p_rose_nowr;
        $rose(flash_busy_out) |-> !flash_wr_out;
    endproperty
    a_rose_nowr: assert property (p_rose_nowr)
        else $error("array write in trigger cycle");

    c_erase: cover property (flash_wr_out && mode_reg == fiw_pkg::FIW_MODE_ERASE);
    c_write: cover property (flash_wr_out && mode_reg == fiw_pkg::FIW_MODE_WRITE);
    c_sat: cover property (wr_in && addr_in == fiw_pkg::REG_DW0_HI && addr_reg[4:0] == 5'h1f);
endmodule

bind fiw_flash_iap fiw_flash_iap_assertions #(
    .ADDR_W(ADDR_W),
    .ERASE_CYCLES(ERASE_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .flash_wr_out(flash_wr_out),
    .flash_addr_out(flash_addr_out),
    .flash_wdata_out(flash_wdata_out),
    .flash_busy_out(flash_busy_out)
);

//--- dv/fiw_flash_iap_bench.sv
`timescale 1ns/1ps
module fiw_flash_iap_bench;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic flash_wr_out;
    logic [12:0] flash_addr_out;
    logic [15:0] flash_wdata_out;
    logic flash_busy_out;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [12:0] q_a[$];
    logic [15:0] q_d[$];
    logic [7:0] d;

    always #5 clk_in = ~clk_in;

    // short counts so that each operation ends within a hundred cycles
    fiw_flash_iap #(.ERASE_CYCLES(40), .WRITE_CYCLES(30), .UNLOCK_CYCLES(50)) DUT (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .flash_wr_out(flash_wr_out),
        .flash_addr_out(flash_addr_out),
        .flash_wdata_out(flash_wdata_out),
        .flash_busy_out(flash_busy_out)
    );

    always @(posedge clk_in) begin
        if (flash_wr_out === 1'b1) begin
            q_a.push_back(flash_addr_out);
            q_d.push_back(flash_wdata_out);
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        v = rdata_out;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string m);
        rd(a, d);
        chk({8'h00, d}, {8'h00, e}, m);
    endtask

    task automatic run_op(input logic [7:0] v, input int n);
        int k;
        q_a.delete();
        q_d.delete();
        wr(fiw_pkg::REG_CTRL0, v);
        k = 0;
        #1;
        while (flash_busy_out !== 1'b0 && k < 500) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        chk(16'(k < 500), 16'h0001, "trigger stuck");
        chk(16'(q_a.size()), 16'(n), "array write count");
    endtask

    // key order is free; the last byte decides match or miss
    task automatic unlock(input logic [7:0] last);
        int k;
        wr(fiw_pkg::REG_CTRL0, 8'h68);
        wr(4'h6, fiw_pkg::KEY_W1_LO);
        wr(4'h8, fiw_pkg::KEY_W2_LO);
        wr(4'ha, fiw_pkg::KEY_W3_LO);
        wr(4'h7, fiw_pkg::KEY_W1_HI);
        wr(4'h9, fiw_pkg::KEY_W2_HI);
        wr(4'hb, last);
        k = 0;
        d = 8'h08;
        while (d[3] !== 1'b0 && k < 100) begin
            rd(fiw_pkg::REG_CTRL0, d);
            k++;
        end
        chk(16'(k < 100), 16'h0001, "unlock timer stuck");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            if (a >= 12) begin
                wr(4'(a), 8'hff);
            end
            rchk(4'(a), 8'h00, "reset value");
        end
        $display("test reset done");
        for (int a = 6; a < 12; a++) begin
            wr(4'(a), 8'h30 + 8'(a));
        end
        for (int a = 6; a < 12; a++) begin
            rchk(4'(a), 8'h30 + 8'(a), "data word");
        end
        $display("test data words done");
        unlock(8'h41);
        rchk(fiw_pkg::REG_CTRL0, 8'h60, "bad key granted");
        unlock(fiw_pkg::KEY_W3_HI);
        rchk(fiw_pkg::REG_CTRL0, 8'he0, "good key refused");
        $display("test unlock done");
        wr(fiw_pkg::REG_ADDR_HI, 8'h02);
        wr(fiw_pkg::REG_ADDR_LO, 8'h5c);
        for (int k = 0; k < 5; k++) begin
            wr(fiw_pkg::REG_DW_FIRST, 8'h10 + 8'(k));
            rchk(fiw_pkg::REG_ADDR_LO, 8'h5c + 8'(k > 3 ? 3 : k), "low byte moved address");
            wr(fiw_pkg::REG_DW0_HI, 8'ha0 + 8'(k));
            rchk(fiw_pkg::REG_ADDR_LO, 8'h5c + 8'(k > 2 ? 3 : k + 1), "address step");
        end
        rchk(fiw_pkg::REG_ADDR_HI, 8'h02, "page changed");
        run_op(8'h84, 4);
        for (int i = 0; i < 4; i++) begin
            chk(16'(q_a[i]), 16'h025c + 16'(i), "write address");
            chk(q_d[i], 16'ha010 + 16'h0101 * 16'(i == 3 ? 4 : i), "write data");
        end
        $display("test page write done");
        wr(fiw_pkg::REG_CTRL2, 8'h01);
        wr(fiw_pkg::REG_ADDR_LO, 8'h40);
        wr(fiw_pkg::REG_DW_FIRST, 8'h55);
        run_op(8'h84, 0);
        wr(fiw_pkg::REG_DW0_HI, 8'h00);
        wr(fiw_pkg::REG_DW0_HI, 8'h00);
        run_op(8'h94, 2);
        for (int i = 0; i < 2; i++) begin
            chk(16'(q_a[i]), 16'h0240 + 16'(i), "erase address");
            chk(q_d[i], 16'h0000, "erase data");
        end
        $display("test erase done");
        run_op(8'hb4, 0);
        wr(fiw_pkg::REG_CTRL0, 8'h00);
        rchk(fiw_pkg::REG_CTRL0, 8'h00, "permission kept");
        wr(fiw_pkg::REG_DW0_HI, 8'h77);
        run_op(8'h04, 0);
        rchk(fiw_pkg::REG_CTRL0, 8'h00, "trigger left set");
        $display("test revoke done");
        wrap_up();
    end
endmodule
